// [core/ast_status_threshold_regs.sv]
// Arming thresholds, device status flags, tick counter, offset value and CRC checks
`timescale 1ns/1ps
module ast_status_threshold_regs
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // Register access
    input  wire ast_pkg::ast_reg_req_s reg_req,
    output logic [7:0]                 reg_rdata_q,
    output logic                       reg_rvalid_q,
    // Initialization control
    input  wire logic                  init_done,
    input  wire logic                  init_lock_set,
    output logic                       init_lock_bit_q,
    // Fault and monitor events
    input  wire ast_pkg::ast_events_s  events,
    // OTP shadow CRC stream
    input  wire ast_pkg::ast_crc_feed_s otp_feed,
    // Stored writable-register CRC field
    input  wire logic [2:0]            wr_crc_expected,
    // Offset canceller result
    input  wire logic                  offset_corr_update,
    input  wire logic [7:0]            offset_corr_in,
    // Arming comparator controls
    output logic [7:0]                 pos_threshold_value_q,
    output logic [7:0]                 neg_threshold_value_q,
    output logic                       pos_compare_enable_q,
    output logic                       neg_compare_enable_q,
    output logic                       arm_function_enable_q
);
    import ast_pkg::*;

    // ========================================================================
    // Reset synchroniser
    // ========================================================================
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ========================================================================
    // Access decode
    // ========================================================================
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
        hit = (addr == off);
    endfunction

    logic status_read;
    logic pos_write;
    logic neg_write;

    assign status_read = reg_req.rd && hit(reg_req.addr, AST_OFF_DEVICE_STATUS);
    assign pos_write   = reg_req.wr && hit(reg_req.addr, AST_OFF_POS_ARM_THRESHOLD)
                         && !init_lock_bit_q;
    assign neg_write   = reg_req.wr && hit(reg_req.addr, AST_OFF_NEG_ARM_THRESHOLD)
                         && !init_lock_bit_q;

    // ========================================================================
    // Initialization lock
    // ========================================================================
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            init_lock_bit_q <= 1'b0;
        end
        else if (init_lock_set)
        begin
            init_lock_bit_q <= 1'b1;
        end
    end

    // ========================================================================
    // Arming thresholds
    // ========================================================================
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pos_threshold_value_q <= AST_THRESHOLD_RESET;
        end
        else if (pos_write)
        begin
            pos_threshold_value_q <= reg_req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            neg_threshold_value_q <= AST_THRESHOLD_RESET;
        end
        else if (neg_write)
        begin
            neg_threshold_value_q <= reg_req.wdata;
        end
    end

    // Comparator enables follow the stored thresholds one cycle later
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pos_compare_enable_q  <= 1'b0;
            neg_compare_enable_q  <= 1'b0;
            arm_function_enable_q <= 1'b0;
        end
        else
        begin
            pos_compare_enable_q  <= (pos_threshold_value_q != AST_THRESHOLD_OFF);
            neg_compare_enable_q  <= (neg_threshold_value_q != AST_THRESHOLD_OFF);
            arm_function_enable_q <= (pos_threshold_value_q != AST_THRESHOLD_OFF)
                                     || (neg_threshold_value_q != AST_THRESHOLD_OFF);
        end
    end

    // ========================================================================
    // Writable-register CRC sequencer
    // ========================================================================
    ast_crc_state_e wr_state_q;
    logic [3:0]     wr_bit_q;
    logic [15:0]    wr_image;
    ast_crc_feed_s  wr_feed;
    logic           wr_mismatch;
    logic           otp_mismatch;

    // Ascending address order, MSB first
    assign wr_image = {pos_threshold_value_q, neg_threshold_value_q};

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wr_state_q <= AST_CRC_IDLE;
        end
        else
        begin
            case (wr_state_q)
                AST_CRC_IDLE:
                begin
                    if (init_lock_bit_q)
                    begin
                        wr_state_q <= AST_CRC_SEED;
                    end
                end
                AST_CRC_SEED:
                begin
                    wr_state_q <= AST_CRC_SHIFT;
                end
                AST_CRC_SHIFT:
                begin
                    if (wr_bit_q == AST_WR_CRC_LAST_BIT)
                    begin
                        wr_state_q <= AST_CRC_CHECK;
                    end
                end
                AST_CRC_CHECK:
                begin
                    wr_state_q <= AST_CRC_SEED;
                end
                default:
                begin
                    wr_state_q <= AST_CRC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wr_bit_q <= 4'h0;
        end
        else if (wr_state_q == AST_CRC_SHIFT)
        begin
            wr_bit_q <= wr_bit_q + 4'h1;
        end
        else
        begin
            wr_bit_q <= 4'h0;
        end
    end

    always_comb
    begin
        wr_feed.start     = (wr_state_q == AST_CRC_SEED);
        wr_feed.bit_valid = (wr_state_q == AST_CRC_SHIFT);
        wr_feed.bit_in    = wr_image[AST_WR_CRC_LAST_BIT - wr_bit_q];
        wr_feed.check     = (wr_state_q == AST_CRC_CHECK);
        wr_feed.expected  = wr_crc_expected;
    end

    ast_crc3 u_wr_crc
    (
        .clk        (core_clk),
        .rst_n      (rst_n_q),
        .feed       (wr_feed),
        .crc_q      (),
        .mismatch_q (wr_mismatch)
    );

    ast_crc3 u_otp_crc
    (
        .clk        (core_clk),
        .rst_n      (rst_n_q),
        .feed       (otp_feed),
        .crc_q      (),
        .mismatch_q (otp_mismatch)
    );

    // ========================================================================
    // Persistent fault sources
    // ========================================================================
    logic wr_crc_fault_q;

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wr_crc_fault_q <= 1'b0;
        end
        else if (wr_mismatch)
        begin
            wr_crc_fault_q <= 1'b1;
        end
    end

    // ========================================================================
    // Status flags; a set in the cycle of a read wins over the clear
    // ========================================================================
    logic internal_data_error_q;
    logic init_in_progress_q;
    logic serial_out_mismatch_q;
    logic offset_monitor_q;
    logic reset_occurred_q;
    logic ide_set;

    // Fuse fault is a level re-presented after every reset
    assign ide_set = otp_mismatch || wr_mismatch || events.internal_fault
                     || wr_crc_fault_q || events.fuse_data_fault;

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            internal_data_error_q <= 1'b0;
        end
        else if (ide_set)
        begin
            internal_data_error_q <= 1'b1;
        end
        else if (status_read)
        begin
            internal_data_error_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            init_in_progress_q <= 1'b1;
        end
        else if (init_done)
        begin
            init_in_progress_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            serial_out_mismatch_q <= 1'b0;
        end
        else if (events.serial_out_mismatch)
        begin
            serial_out_mismatch_q <= 1'b1;
        end
        else if (status_read)
        begin
            serial_out_mismatch_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            offset_monitor_q <= 1'b0;
        end
        else if (events.offset_limit)
        begin
            offset_monitor_q <= 1'b1;
        end
        else if (status_read)
        begin
            offset_monitor_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            reset_occurred_q <= 1'b0;
        end
        else if (init_in_progress_q)
        begin
            reset_occurred_q <= 1'b1;
        end
        else if (status_read)
        begin
            reset_occurred_q <= 1'b0;
        end
    end

    // ========================================================================
    // Counter and offset correction
    // ========================================================================
    logic [7:0] tick_count;
    logic [7:0] offset_corr_q;

    ast_tick_counter u_tick
    (
        .clk     (core_clk),
        .rst_n   (rst_n_q),
        .count_q (tick_count)
    );

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            offset_corr_q <= AST_OFFSET_CORR_RESET;
        end
        else if (offset_corr_update)
        begin
            offset_corr_q <= offset_corr_in;
        end
    end

    // ========================================================================
    // Read data
    // ========================================================================
    logic [7:0] status_word;
    logic [7:0] rd_mux;

    // Unused bits 7 and 5 and bit 2 read as zero
    always_comb
    begin
        status_word                              = AST_READ_ZERO;
        status_word[AST_BIT_RESET_OCCURRED]      = reset_occurred_q;
        status_word[AST_BIT_OFFSET_MONITOR]      = offset_monitor_q;
        status_word[AST_BIT_SERIAL_OUT_MISMATCH] = serial_out_mismatch_q;
        status_word[AST_BIT_INIT_IN_PROGRESS]    = init_in_progress_q;
        status_word[AST_BIT_INTERNAL_DATA_ERROR] = internal_data_error_q;
    end

    // Reserved and unmapped locations read zero; writes to them are dropped
    always_comb
    begin
        if (hit(reg_req.addr, AST_OFF_POS_ARM_THRESHOLD))
        begin
            rd_mux = pos_threshold_value_q;
        end
        else if (hit(reg_req.addr, AST_OFF_NEG_ARM_THRESHOLD))
        begin
            rd_mux = neg_threshold_value_q;
        end
        else if (hit(reg_req.addr, AST_OFF_DEVICE_STATUS))
        begin
            rd_mux = status_word;
        end
        else if (hit(reg_req.addr, AST_OFF_TICK_COUNTER))
        begin
            rd_mux = tick_count;
        end
        else if (hit(reg_req.addr, AST_OFF_OFFSET_CORR))
        begin
            rd_mux = offset_corr_q;
        end
        else
        begin
            rd_mux = AST_READ_ZERO;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            reg_rdata_q  <= AST_READ_ZERO;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= reg_req.rd;
            if (reg_req.rd)
            begin
                reg_rdata_q <= rd_mux;
            end
        end
    end

endmodule

// [core/ast_pkg.sv]
// Package of offsets, field positions, reset values and types for the status/threshold bank
package ast_pkg;

    // ========================================================================
    // Register offsets
    // ========================================================================
    localparam logic [5:0] AST_OFF_POS_ARM_THRESHOLD = 6'h10;
    localparam logic [5:0] AST_OFF_NEG_ARM_THRESHOLD = 6'h12;
    localparam logic [5:0] AST_OFF_DEVICE_STATUS     = 6'h14;
    localparam logic [5:0] AST_OFF_TICK_COUNTER      = 6'h15;
    localparam logic [5:0] AST_OFF_OFFSET_CORR       = 6'h16;
    localparam logic [5:0] AST_OFF_RESERVED_A        = 6'h1c;
    localparam logic [5:0] AST_OFF_RESERVED_B        = 6'h1d;

    // ========================================================================
    // Status field positions
    // ========================================================================
    localparam int AST_BIT_RESET_OCCURRED      = 0;
    localparam int AST_BIT_OFFSET_MONITOR      = 1;
    localparam int AST_BIT_SERIAL_OUT_MISMATCH = 3;
    localparam int AST_BIT_INIT_IN_PROGRESS    = 4;
    localparam int AST_BIT_INTERNAL_DATA_ERROR = 6;

    // ========================================================================
    // Reset values and counts
    // ========================================================================
    localparam logic [7:0] AST_THRESHOLD_RESET   = 8'h00;
    localparam logic [7:0] AST_THRESHOLD_OFF     = 8'h00;
    localparam logic [7:0] AST_COUNT_RESET       = 8'h00;
    localparam logic [7:0] AST_OFFSET_CORR_RESET = 8'h00;
    localparam logic [7:0] AST_READ_ZERO         = 8'h00;
    localparam logic [2:0] AST_CRC_SEED_VALUE    = 3'h7;
    localparam logic [9:0] AST_PRESCALE_LAST     = 10'h3ff;
    localparam logic [3:0] AST_WR_CRC_LAST_BIT   = 4'hf;

    // ========================================================================
    // Types
    // ========================================================================
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } ast_reg_req_s;

    typedef struct packed {
        logic serial_out_mismatch;
        logic offset_limit;
        logic internal_fault;
        logic fuse_data_fault;
    } ast_events_s;

    typedef struct packed {
        logic       start;
        logic       bit_valid;
        logic       bit_in;
        logic       check;
        logic [2:0] expected;
    } ast_crc_feed_s;

    typedef enum logic [3:0] {
        AST_CRC_IDLE  = 4'h1,
        AST_CRC_SEED  = 4'h2,
        AST_CRC_SHIFT = 4'h4,
        AST_CRC_CHECK = 4'h8
    } ast_crc_state_e;

endpackage

// [core/ast_crc3.sv]
// Serial 3-bit CRC engine, polynomial x^3+x+1, all-ones seed
`timescale 1ns/1ps
module ast_crc3
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Bit stream and check strobe
    input  wire ast_pkg::ast_crc_feed_s feed,
    // Result
    output logic [2:0]                 crc_q,
    output logic                       mismatch_q
);
    import ast_pkg::*;

    logic feedback;

    assign feedback = feed.bit_in ^ crc_q[2];

    // ========================================================================
    // Shift register, MSB of the data first
    // ========================================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            crc_q <= AST_CRC_SEED_VALUE;
        end
        else if (feed.start)
        begin
            crc_q <= AST_CRC_SEED_VALUE;
        end
        else if (feed.bit_valid)
        begin
            crc_q <= {crc_q[1], crc_q[0] ^ feedback, feedback};
        end
    end

    // ========================================================================
    // Compare against the stored field; one-cycle pulse on a difference
    // ========================================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mismatch_q <= 1'b0;
        end
        else
        begin
            mismatch_q <= feed.check && (crc_q != feed.expected);
        end
    end

endmodule

// [core/ast_tick_counter.sv]
// Free-running 8-bit counter advanced once per 1024 clock periods
`timescale 1ns/1ps
module ast_tick_counter
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Counter value
    output logic [7:0]      count_q
);
    import ast_pkg::*;

    logic [9:0] prescale_q;

    // ========================================================================
    // 10-bit prescaler and rolling counter
    // ========================================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prescale_q <= 10'h000;
        end
        else
        begin
            prescale_q <= prescale_q + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= AST_COUNT_RESET;
        end
        else if (prescale_q == AST_PRESCALE_LAST)
        begin
            count_q <= count_q + 8'h01;
        end
    end

endmodule

// [verif/ast_props.sv]
// Port checker for the status and threshold register bank
`timescale 1ns/1ps
module ast_props
(
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  reset_n,
    // Watched ports
    input wire ast_pkg::ast_reg_req_s reg_req,
    input wire logic [7:0]            reg_rdata_q,
    input wire logic                  reg_rvalid_q,
    input wire logic                  init_lock_bit_q,
    input wire logic [7:0]            pos_threshold_value_q,
    input wire logic [7:0]            neg_threshold_value_q,
    input wire logic                  pos_compare_enable_q,
    input wire logic                  arm_function_enable_q
);
    import ast_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // =====================================================================
    // Sequences
    // =====================================================================
    sequence rd_at(logic [5:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    sequence wr_pos;
        reg_req.wr && reg_req.addr == AST_OFF_POS_ARM_THRESHOLD;
    endsequence
    // =====================================================================
    // Properties
    // =====================================================================
    chk_rvalid_track: assert property (reg_rvalid_q == $past(reg_req.rd))
        else $error("read valid out of step");
    chk_lock_sticky: assert property (init_lock_bit_q |=> init_lock_bit_q)
        else $error("lock bit dropped");
    chk_locked_ignore: assert property (init_lock_bit_q ##0 wr_pos |=>
        $stable(pos_threshold_value_q)) else $error("locked threshold changed");
    chk_open_write: assert property (!init_lock_bit_q ##0 wr_pos |=>
        pos_threshold_value_q == $past(reg_req.wdata)) else $error("threshold not written");
    chk_pos_enable: assert property (pos_compare_enable_q ==
        ($past(pos_threshold_value_q) != 8'h00)) else $error("pos enable wrong");
    chk_arm_enable: assert property (arm_function_enable_q ==
        ($past(pos_threshold_value_q | neg_threshold_value_q) != 8'h00))
        else $error("arm enable wrong");
    chk_status_spare: assert property (rd_at(AST_OFF_DEVICE_STATUS) |=>
        reg_rdata_q[7] == 1'b0 && reg_rdata_q[5] == 1'b0 && reg_rdata_q[2] == 1'b0)
        else $error("spare status bit set");
    chk_rsvd_zero: assert property ((rd_at(AST_OFF_RESERVED_A) or
        rd_at(AST_OFF_RESERVED_B)) |=> reg_rdata_q == 8'h00) else $error("reserved not zero");
endmodule
bind ast_status_threshold_regs ast_props u_ast_props
(
    .core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .init_lock_bit_q(init_lock_bit_q),
    .pos_threshold_value_q(pos_threshold_value_q),
    .neg_threshold_value_q(neg_threshold_value_q),
    .pos_compare_enable_q(pos_compare_enable_q), .arm_function_enable_q(arm_function_enable_q)
);

// [verif/ast_host.sv]
// Host model issuing register reads and writes
`timescale 1ns/1ps
module ast_host
(
    // Clock
    input wire logic             core_clk,
    // Register port
    output ast_pkg::ast_reg_req_s reg_req,
    input wire logic [7:0]       reg_rdata_q,
    input wire logic             reg_rvalid_q
);
    import ast_pkg::*;
    initial reg_req = '0;
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{1'b1, 1'b0, a, (a == 6'h1c || a == 6'h1d) ? 8'h00 : d};
        @(negedge core_clk);
        reg_req = '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{1'b0, 1'b1, a, 8'h55};
        @(negedge core_clk);
        // Data is taken with the valid pulse; a missing valid reads as unknown
        d = reg_rvalid_q ? reg_rdata_q : 8'hxx;
        reg_req = '{1'b0, 1'b0, ~a, 8'haa};
    endtask
endmodule

// [verif/tb_top.sv]
// Random and corner-case bench for the status and threshold register bank
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb_top;
    import ast_pkg::*;
    localparam logic [5:0] ST = AST_OFF_DEVICE_STATUS;
    localparam logic [5:0] PT = AST_OFF_POS_ARM_THRESHOLD;
    localparam logic [5:0] NT = AST_OFF_NEG_ARM_THRESHOLD;
    logic          clk = 0, rst_n = 0, done = 0, lock_set = 0, upd = 0;
    logic [7:0]    corr = 0, rd_q, r, p, n, v, pos_q, neg_q;
    logic          rv_q, lock_q, pen_q, nen_q, arm_q;
    logic [2:0]    wexp = 3'h7;
    logic [31:0]   lfsr = 32'h8e9e2f54;
    ast_reg_req_s  req;
    ast_events_s   ev = '0;
    ast_crc_feed_s otp = '0;
    int            n_errors = 0, compares = 0, cyc = 0;
    int            eb[3] = '{6, 1, 3};
    always #12.5 clk = ~clk;
    ast_status_threshold_regs u_ast_status_threshold_regs (.core_clk(clk), .reset_n(rst_n),
        .reg_req(req), .reg_rdata_q(rd_q), .reg_rvalid_q(rv_q), .init_done(done),
        .init_lock_set(lock_set), .init_lock_bit_q(lock_q), .events(ev), .otp_feed(otp),
        .wr_crc_expected(wexp), .offset_corr_update(upd), .offset_corr_in(corr),
        .pos_threshold_value_q(pos_q), .neg_threshold_value_q(neg_q),
        .pos_compare_enable_q(pen_q), .neg_compare_enable_q(nen_q), .arm_function_enable_q(arm_q));
    ast_host u_ast_host (.core_clk(clk), .reg_req(req), .reg_rdata_q(rd_q), .reg_rvalid_q(rv_q));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    function automatic logic [2:0] crc3(input logic [15:0] w, input int nb);
        logic [2:0] c;
        logic       fb;
        c = 3'h7;
        for (int i = nb - 1; i >= 0; i--)
        begin
            fb = w[i] ^ c[2];
            c = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        u_ast_host.rd(a, r);
        `CHK($sformatf("reg %h", a), e, r)
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rchk(PT, 8'h00);
        rchk(AST_OFF_TICK_COUNTER, 8'h00);
        rchk(AST_OFF_OFFSET_CORR, 8'h00);
        rchk(ST, 8'h11);
        rchk(ST, 8'h11);
        done = 1'b1;
        rchk(ST, 8'h01);
        rchk(ST, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            p = (k == 1 || k == 2) ? 8'h00 : rnd();
            n = (k == 0 || k == 2) ? 8'h00 : rnd();
            u_ast_host.wr(PT, p);
            u_ast_host.wr(NT, n);
            rchk(PT, p);
            rchk(NT, n);
            `CHK("pos_en", p != 8'h00, pen_q)
            `CHK("neg_en", n != 8'h00, nen_q)
            `CHK("arm_en", (p | n) != 8'h00, arm_q)
        end
        for (int i = 1; i < 4; i++)
        begin
            ev[i] = 1'b1;
            @(negedge clk) ev[i] = 1'b0;
            rchk(ST, 8'h01 << eb[i - 1]);
            rchk(ST, 8'h00);
        end
        corr = rnd();
        upd = 1'b1;
        @(negedge clk) upd = 1'b0;
        u_ast_host.wr(AST_OFF_OFFSET_CORR, ~corr);
        rchk(AST_OFF_OFFSET_CORR, corr);
        u_ast_host.wr(AST_OFF_RESERVED_A, 8'h00);
        rchk(AST_OFF_RESERVED_A, 8'h00);
        rchk(6'h3f, 8'h00);
        for (int j = 0; j < 2; j++)
        begin
            v = rnd();
            otp = '{1'b1, 1'b0, 1'b0, 1'b0, crc3({8'h00, v}, 8) ^ 3'(j)};
            for (int b = 7; b >= 0; b--)
                @(negedge clk) otp = '{1'b0, 1'b1, v[b], 1'b0, otp.expected};
            @(negedge clk) otp = '{1'b0, 1'b0, 1'b0, 1'b1, otp.expected};
            @(negedge clk) otp.check = 1'b0;
            repeat (3) @(negedge clk);
            rchk(ST, j ? 8'h40 : 8'h00);
        end
        rchk(ST, 8'h00);
        wexp = crc3({p, n}, 16);
        lock_set = 1'b1;
        @(negedge clk) lock_set = 1'b0;
        u_ast_host.wr(PT, ~p);
        repeat (40) @(negedge clk);
        rchk(PT, p);
        rchk(ST, 8'h00);
        wexp = ~wexp;
        repeat (40) @(negedge clk);
        rchk(ST, 8'h40);
        rchk(ST, 8'h40);
        u_ast_host.rd(AST_OFF_TICK_COUNTER, v);
        repeat (1022) @(negedge clk);
        rchk(AST_OFF_TICK_COUNTER, v + 8'h01);
        ev.fuse_data_fault = 1'b1;
        done = 1'b0;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("lock", 1'b0, lock_q)
        rchk(ST, 8'h51);
        give_verdict();
    end
endmodule
